// [msfb_pkg.sv]
// shared constants and carrier types for the motion status flag bank
`default_nettype none
package msfb_pkg;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_EVENT    = 8'h1B;
	localparam logic [7:0] IDX_FEATURE  = 8'h1C;
	localparam logic [7:0] IDX_CORE     = 8'h1D;
	localparam logic [7:0] IDX_PACE_LO  = 8'h1E;
	localparam logic [7:0] IDX_PACE_HI  = 8'h1F;
	localparam logic [7:0] IDX_GEST_ACT = 8'h20;
	localparam logic [7:0] IDX_IRQ_STAT = 8'h30;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h31;

	// ----------------------------------------------------------------
	// field layout and reset values
	// ----------------------------------------------------------------
	localparam int         POS_POR       = 0;
	localparam int         POS_ERR_LO    = 2;
	localparam int         POS_ACT_LO    = 3;
	localparam logic [7:0] RST_EVENT     = 8'h01;
	localparam logic [7:0] RST_ZERO      = 8'h00;
	localparam logic [2:0] ERR_NONE      = 3'h0;
	localparam logic [2:0] ERR_ACCEL     = 3'h1;
	localparam logic [2:0] ERR_GYRO      = 3'h2;
	localparam logic [2:0] ERR_BOTH      = 3'h3;
	localparam logic [2:0] GEST_UNKNOWN  = 3'h0;
	localparam logic [1:0] ACT_UNKNOWN   = 2'h3;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	// interrupt status / mask layout
	localparam int IRQ_W        = 3;
	localparam int IRQ_FEATURE  = 0;
	localparam int IRQ_CORE     = 1;
	localparam int IRQ_RESULT   = 2;

	// core data-path events, packed as they sit in the core flag byte
	typedef struct packed {
		logic accel_ready;
		logic gyro_ready;
		logic aux_ready;
		logic [1:0] unused;
		logic error;
		logic fifo_watermark;
		logic fifo_full;
	} msfb_core_t;

	// feature engine result: gesture and activity codes
	typedef struct packed {
		logic [1:0] activity;
		logic [2:0] gesture;
	} msfb_result_t;

endpackage : msfb_pkg
`default_nettype wire

// [msfb_bank.sv]
// motion status flag bank: read-only flag registers behind an AHB-Lite slave
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module msfb_bank
	import msfb_pkg::*;
#(
	parameter int ADDR_W = 32
) (
	// clock, reset, enable
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic               ce,
	// ahb-lite slave
	input  wire logic               hsel,
	input  wire logic [ADDR_W-1:0]  haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic                    hreadyout,
	output logic                    hresp,
	output logic [31:0]             hrdata,
	// feature and data-path engines
	input  wire logic               soft_reset,
	input  wire logic [6:0]         feature_evt,
	input  wire msfb_core_t         core_evt,
	input  wire logic               accel_cfg_fault,
	input  wire logic               gyro_cfg_fault,
	input  wire logic [15:0]        pace_count,
	input  wire logic               pace_valid,
	input  wire msfb_result_t       result,
	input  wire logic               result_valid,
	input  wire logic               init_done,
	// interrupt
	output logic                    irq
);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (ADDR_W < 10) begin : g_addr_check
		$error("ADDR_W must be at least 10");
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic               por_flag;
	logic [2:0]         err_code;
	logic [6:0]         feature_flags;
	msfb_core_t         core_flags;
	logic [15:0]        pace;
	msfb_result_t       gest_act;
	logic [IRQ_W-1:0]   irq_stat;
	logic [IRQ_W-1:0]   irq_mask;
	logic               wr_pend;
	logic [7:0]         wr_idx;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic               take;
	logic               rd_take;
	logic               wr_take;
	logic [7:0]         idx;
	logic [7:0]         core_mask;

	// only whole-word transfers are served; other sizes are answered but do nothing
	assign take      = ce & hsel & hready & (htrans == HTRANS_NONSEQ) & (hsize == 3'h2);
	assign rd_take   = take & ~hwrite;
	assign wr_take   = take & hwrite;
	assign idx       = haddr[9:2];
	assign core_mask = 8'hE7;

	// zero wait states; a low enable stretches the data phase and drops engine events
	assign hreadyout = ce;
	assign hresp     = 1'b0;

	// read value of one register, taken before any clear
	function automatic logic [7:0] read_mux(input logic [7:0] i);
		logic [7:0] v;
		v = RST_ZERO;
		case (i)
			IDX_EVENT:    v = {3'h0, err_code, 1'b0, por_flag};
			IDX_FEATURE:  v = {1'b0, feature_flags};
			IDX_CORE:     v = core_flags & core_mask;
			IDX_PACE_LO:  v = pace[7:0];
			IDX_PACE_HI:  v = pace[15:8];
			IDX_GEST_ACT: v = {3'h0, gest_act};
			IDX_IRQ_STAT: v = {5'h00, irq_stat};
			IDX_IRQ_MASK: v = {5'h00, irq_mask};
			default:      v = RST_ZERO;
		endcase
		return v;
	endfunction : read_mux

	// clear strobes fire on the edge the byte is latched onto hrdata
	logic clr_event;
	logic clr_feature;
	logic clr_core;
	logic clr_irq;

	assign clr_event   = rd_take & (idx == IDX_EVENT);
	assign clr_feature = rd_take & (idx == IDX_FEATURE);
	assign clr_core    = rd_take & (idx == IDX_CORE);
	assign clr_irq     = rd_take & (idx == IDX_IRQ_STAT);

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	// read data is registered in the address phase, so it stands through the data phase
	always_ff @(posedge clk) begin
		if (rst) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_take) begin
			hrdata <= {24'h00_0000, read_mux(idx)};
		end
	end

	// ----------------------------------------------------------------
	// write path: only the interrupt mask accepts data
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_pend <= 1'b0;
			wr_idx  <= 8'h00;
		end else if (ce && hready) begin
			wr_pend <= wr_take;
			wr_idx  <= idx;
		end
	end

	// only irq_mask has a write path, so a write cannot disturb the flag registers
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_mask <= '0;
		end else if (ce && wr_pend && wr_idx == IDX_IRQ_MASK) begin
			irq_mask <= hwdata[IRQ_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// system event register
	// ----------------------------------------------------------------
	// a soft reset in the clearing cycle wins over the clear
	always_ff @(posedge clk) begin
		if (rst) begin
			por_flag <= RST_EVENT[POS_POR];
		end else if (ce) begin
			if (soft_reset) begin
				por_flag <= 1'b1;
			end else if (clr_event) begin
				por_flag <= 1'b0;
			end
		end
	end

	// fault code follows the live config checks; it is persistent, so a read leaves it
	always_ff @(posedge clk) begin
		if (rst) begin
			err_code <= ERR_NONE;
		end else if (ce) begin
			case ({gyro_cfg_fault, accel_cfg_fault})
				2'b01:   err_code <= ERR_ACCEL;
				2'b10:   err_code <= ERR_GYRO;
				2'b11:   err_code <= ERR_BOTH;
				default: err_code <= ERR_NONE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// feature and core flag registers
	// ----------------------------------------------------------------
	// sticky flags; a new event in the clearing cycle survives the clear
	always_ff @(posedge clk) begin
		if (rst) begin
			feature_flags <= RST_ZERO[6:0];
		end else if (ce) begin
			feature_flags <= (clr_feature ? 7'h00 : feature_flags) | feature_evt;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			core_flags <= RST_ZERO;
		end else if (ce) begin
			core_flags <= ((clr_core ? RST_ZERO : core_flags) | core_evt) & core_mask;
		end
	end

	// ----------------------------------------------------------------
	// step count and gesture/activity results
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			pace <= {RST_ZERO, RST_ZERO};
		end else if (ce && pace_valid) begin
			pace <= pace_count;
		end
	end

	// init forces the unknown activity; a result in the same cycle is newer and wins
	always_ff @(posedge clk) begin
		if (rst) begin
			gest_act <= RST_ZERO[4:0];
		end else if (ce) begin
			if (result_valid) begin
				gest_act <= result;
			end else if (init_done) begin
				gest_act <= {ACT_UNKNOWN, GEST_UNKNOWN};
			end
		end
	end

	// ----------------------------------------------------------------
	// interrupt status, mask and output
	// ----------------------------------------------------------------
	logic [IRQ_W-1:0] irq_set;

	assign irq_set[IRQ_FEATURE] = |feature_evt;
	assign irq_set[IRQ_CORE]    = |(core_evt & core_mask);
	assign irq_set[IRQ_RESULT]  = result_valid;

	always_ff @(posedge clk) begin
		if (rst) begin
			irq_stat <= '0;
		end else if (ce) begin
			irq_stat <= (clr_irq ? '0 : irq_stat) | irq_set;
		end
	end

	// level output, so an unmasked flag left pending keeps the line up
	assign irq = |(irq_stat & irq_mask);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_event_read;
		rd_take && idx == IDX_EVENT && !soft_reset;
	endsequence

	sequence s_core_read_quiet;
		rd_take && idx == IDX_CORE && core_evt == RST_ZERO;
	endsequence

	// event read returns the pre-clear flag and clears it on the same edge that latches it
	event_clear_a: assert property (
		s_event_read |=> (!por_flag && hrdata[POS_POR] == $past(por_flag))
	) else $error("event register not cleared by read");

	// soft reset raises the power-on flag on the next edge
	por_set_a: assert property (
		(ce && soft_reset) |=> por_flag
	) else $error("power-on flag not set after soft reset");

	// fault code matches the fault inputs of the previous cycle
	fault_code_a: assert property (
		ce |=> err_code == {1'b0, $past(gyro_cfg_fault), $past(accel_cfg_fault)}
	) else $error("config fault code wrong");

	// feature read with no new event leaves the register empty
	feature_clear_a: assert property (
		(clr_feature && feature_evt == 7'h00) |=> feature_flags == 7'h00
	) else $error("feature flags not cleared by read");

	// each feature event lands on its own bit on the next edge
	feature_bits_a: assert property (
		(ce && feature_evt != 7'h00) |=> ((feature_flags & $past(feature_evt)) == $past(feature_evt))
	) else $error("feature event bit missing");

	// feature read returns the pre-clear flags with the reserved bit zero
	feature_rsvd_a: assert property (
		rd_take && idx == IDX_FEATURE |=> hrdata[7:0] == {1'b0, $past(feature_flags)}
	) else $error("feature read value wrong");

	// a quiet core read clears the register and holds it clear while quiet
	core_clear_a: assert property (
		s_core_read_quiet ##1 (ce && core_evt == RST_ZERO) |=> core_flags == RST_ZERO
	) else $error("core flags not cleared by read");

	// core bits 3 and 4 never set
	core_rsvd_a: assert property (
		core_flags.unused == 2'b00
	) else $error("core reserved bits set");

	// a high step byte read matches the stored count unless a new count lands in the read cycle
	pace_bytes_a: assert property (
		rd_take && idx == IDX_PACE_HI |=> hrdata[7:0] == pace[15:8] || $past(pace_valid)
	) else $error("step count high byte wrong");

	// a reported result shows in the gesture/activity register a cycle later
	result_load_a: assert property (
		(ce && result_valid) |=> gest_act == $past(result)
	) else $error("gesture or activity result not stored");

	// initialization alone yields the unknown activity code
	init_act_a: assert property (
		(ce && init_done && !result_valid) |=> gest_act.activity == ACT_UNKNOWN
	) else $error("activity not unknown after init");

	// an event in the clearing cycle survives the clear
	set_wins_a: assert property (
		(clr_feature && feature_evt != 7'h00) |=> feature_flags == $past(feature_evt)
	) else $error("event lost during clearing read");

	// a write to any register but the interrupt mask leaves the feature flags unchanged
	write_ignored_a: assert property (
		(ce && wr_pend && wr_idx != IDX_IRQ_MASK && feature_evt == 7'h00 && !clr_feature)
			|=> feature_flags == $past(feature_flags)
	) else $error("write disturbed a flag");

	// an unmasked pending flag keeps the line up until a status read or a mask write
	irq_level_a: assert property (
		(ce && !clr_irq && !(wr_pend && wr_idx == IDX_IRQ_MASK) && (irq_stat & irq_mask) != '0) |=> irq
	) else $error("interrupt output mismatch");

endmodule : msfb_bank

`default_nettype wire

// [msfb_engine_model.sv]
// behavioural model of the feature and data-path engines feeding the flag bank
`timescale 1ns/100ps
`default_nettype none

module msfb_engine_model
	import msfb_pkg::*;
(
	// clock
	input  wire logic        clk,
	// event pulses
	output logic             soft_reset,
	output logic [6:0]       feature_evt,
	output var msfb_core_t   core_evt,
	output logic             init_done,
	// fault levels
	output logic             accel_cfg_fault,
	output logic             gyro_cfg_fault,
	// step count and result
	output logic [15:0]      pace_count,
	output logic             pace_valid,
	output var msfb_result_t result,
	output logic             result_valid
);
	// idle state at time zero
	initial begin
		{soft_reset, feature_evt, core_evt, init_done} = '0;
		{accel_cfg_fault, gyro_cfg_fault, pace_valid, result_valid} = '0;
		pace_count = 16'h0000;
		result = '0;
	end

	// one-cycle event pulses, launched just after an edge
	task automatic fire(input logic [6:0] f, input logic [7:0] c, input logic s, input logic i);
		@(posedge clk);
		feature_evt <= f;
		core_evt <= c;
		soft_reset <= s;
		init_done <= i;
		@(posedge clk);
		{soft_reset, feature_evt, core_evt, init_done} <= '0;
	endtask : fire

	// data valid for one cycle; afterwards the lines no longer hold the value
	task automatic data(input logic pv, input logic [15:0] pc, input logic rv, input logic [4:0] r);
		@(posedge clk);
		{pace_valid, pace_count, result_valid, result} <= {pv, pc, rv, r};
		@(posedge clk);
		{pace_valid, result_valid} <= 2'h0;
		pace_count <= ~pc;
		result <= ~r;
	endtask : data

	// persistent configuration fault levels
	task automatic faults(input logic a, input logic g);
		@(posedge clk);
		{accel_cfg_fault, gyro_cfg_fault} <= {a, g};
	endtask : faults
endmodule : msfb_engine_model
`default_nettype wire

// [tb_motion_status_flag_bank.sv]
// self-checking testbench for the motion status flag bank
`timescale 1ns/100ps
`default_nettype none

module tb_motion_status_flag_bank
	import msfb_pkg::*;
;
	logic clk, rst, ce, hsel, hwrite, hreadyout, hresp, irq;
	logic [31:0] haddr, hwdata, hrdata, rd, r;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic soft_reset, init_done, accel_cfg_fault, gyro_cfg_fault, pace_valid, result_valid;
	logic [6:0] feature_evt;
	logic [15:0] pace_count;
	msfb_core_t core_evt;
	msfb_result_t result;
	int fail_count, num_checks, seed;
	logic [6:0] f;
	logic [7:0] c;

	// ----------------------------------------------------------------
	// design and engine model
	// ----------------------------------------------------------------
	msfb_bank dut (.clk(clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .soft_reset(soft_reset), .feature_evt(feature_evt),
		.core_evt(core_evt), .accel_cfg_fault(accel_cfg_fault), .gyro_cfg_fault(gyro_cfg_fault),
		.pace_count(pace_count), .pace_valid(pace_valid), .result(result),
		.result_valid(result_valid), .init_done(init_done), .irq(irq));
	msfb_engine_model eng (.clk(clk), .soft_reset(soft_reset), .feature_evt(feature_evt),
		.core_evt(core_evt), .init_done(init_done), .accel_cfg_fault(accel_cfg_fault),
		.gyro_cfg_fault(gyro_cfg_fault), .pace_count(pace_count), .pace_valid(pace_valid),
		.result(result), .result_valid(result_valid));

	// ----------------------------------------------------------------
	// clock, bus tasks, expectations
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// single word transfer; waits on hready, a slow slave just stretches it
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] d);
		@(posedge clk);
		{htrans, haddr, hwrite} <= {HTRANS_NONSEQ, a, w};
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		d = hrdata;
	endtask : bus

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic rchk(input logic [31:0] a, input logic [7:0] e, input string what);
		logic [31:0] d;
		bus(1'b0, a, 32'h0, d);
		check(what, d, {24'h0, e});
	endtask : rchk

	function automatic logic [7:0] exp_evt(input logic por, input logic [1:0] code);
		return {4'h0, code, 1'b0, por};
	endfunction : exp_evt

	function automatic logic [7:0] exp_res(input logic [1:0] a, input logic [2:0] g);
		return {3'h0, a, g};
	endfunction : exp_res

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : summarize

	// watchdog: the whole run needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		summarize();
	end

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		seed = 32'hF630;
		{rst, ce, hsel, haddr, htrans, hwrite, hsize, hwdata} = {3'h7, 32'h0, 3'h0, 3'h2, 32'h0};
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		// reset values, power-on flag cleared by its read
		rchk(32'h6C, 8'h01, "por set");
		rchk(32'h6C, 8'h00, "por clear");
		for (int a = 'h70; a <= 'h80; a += 4) rchk(a, 8'h00, "reset zero");
		check("irq idle", {31'h0, irq}, 32'h0);
		check("hresp", {31'h0, hresp}, 32'h0);
		$display("test reset done");
		// every fault code, persistent across reads
		for (int i = 0; i < 4; i++) begin
			eng.faults(i[0], i[1]);
			rchk(32'h6C, exp_evt(1'b0, i[1:0]), "fault code");
			rchk(32'h6C, exp_evt(1'b0, i[1:0]), "fault kept");
		end
		eng.faults(1'b0, 1'b0);
		eng.fire(7'h0, 8'h0, 1'b1, 1'b0);
		rchk(32'h6C, 8'h01, "soft reset");
		$display("test event done");
		// random feature and core flags, each cleared by its read
		for (int i = 0; i < 8; i++) begin
			r = $random(seed);
			f = (i == 0) ? 7'h7F : r[6:0];
			c = (i == 0) ? 8'hFF : r[15:8];
			eng.fire(f, c, 1'b0, 1'b0);
			rchk(32'h70, {1'b0, f}, "feature");
			rchk(32'h70, 8'h00, "feature clr");
			rchk(32'h74, c & 8'hE7, "core");
			rchk(32'h74, 8'h00, "core clr");
			eng.data(1'b1, r[31:16], 1'b0, 5'h0);
			rchk(32'h78, r[23:16], "pace low");
			rchk(32'h7C, r[31:24], "pace high");
		end
		for (int i = 0; i < 7; i++) begin
			eng.fire(7'h1 << i, 8'h0, 1'b0, 1'b0);
			rchk(32'h70, 8'h1 << i, "feature bit");
		end
		$display("test flags done");
		// gesture codes 0 to 5 and every activity code, then the init value
		for (int g = 0; g < 6; g++) begin
			eng.data(1'b0, 16'h0, 1'b1, {g[1:0] ^ 2'h1, g[2:0]});
			rchk(32'h80, exp_res(g[1:0] ^ 2'h1, g[2:0]), "result");
		end
		for (int a = 0; a < 4; a++) begin
			eng.data(1'b0, 16'h0, 1'b1, {a[1:0], 3'h5});
			rchk(32'h80, exp_res(a[1:0], 3'h5), "activity");
		end
		eng.fire(7'h0, 8'h0, 1'b0, 1'b1);
		rchk(32'h80, exp_res(ACT_UNKNOWN, 3'h0), "init");
		$display("test result done");
		// event arriving at the edge of a clearing read survives it
		fork
			bus(1'b0, 32'h70, 32'h0, rd);
			eng.fire(7'h40, 8'h01, 1'b0, 1'b0);
		join
		check("race read", rd, 32'h0);
		rchk(32'h70, 8'h40, "race kept");
		rchk(32'h74, 8'h01, "race core");
		// writes change nothing; unmapped place reads zero
		eng.fire(7'h02, 8'h0, 1'b0, 1'b0);
		for (int a = 'h6C; a <= 'h80; a += 4) bus(1'b1, a, 32'hFFFF_FFFF, rd);
		bus(1'b1, 32'h100, 32'hFFFF_FFFF, rd);
		rchk(32'h70, 8'h02, "write ignored");
		rchk(32'h7C, r[31:24], "pace kept");
		rchk(32'h100, 8'h00, "unmapped");
		$display("test write done");
		// a low enable stalls the bus and ignores events, so nothing is captured
		ce <= 1'b0;
		eng.fire(7'h10, 8'h0, 1'b0, 1'b0);
		check("stall", {31'h0, hreadyout}, 32'h0);
		ce <= 1'b1;
		rchk(32'h70, 8'h00, "frozen");
		$display("test enable done");
		// interrupt raised, cleared by status read, then masked
		rchk(32'hC0, 8'h07, "irq status");
		bus(1'b1, 32'hC4, 32'h7, rd);
		eng.fire(7'h01, 8'h0, 1'b0, 1'b0);
		@(negedge clk);
		check("irq on", {31'h0, irq}, 32'h1);
		rchk(32'hC0, 8'h01, "irq status");
		@(negedge clk);
		check("irq off", {31'h0, irq}, 32'h0);
		rchk(32'hC4, 8'h07, "mask");
		bus(1'b1, 32'hC4, 32'h0, rd);
		eng.fire(7'h0, 8'h04, 1'b0, 1'b0);
		@(negedge clk);
		check("irq masked", {31'h0, irq}, 32'h0);
		rchk(32'hC0, 8'h02, "irq status");
		$display("test irq done");
		summarize();
	end
endmodule : tb_motion_status_flag_bank
`default_nettype wire
